// >>> common/srx_pkg.sv
// Shared constants and types for the string, repeat and add/subtract executor
`default_nettype none
package srx_pkg;
   typedef enum logic [3:0] {
      srx_op_none, srx_op_block_move, srx_op_block_compare, srx_op_compare_with_accumulator,
      srx_op_load_string, srx_op_store_string, srx_op_bit_field_insert,
      srx_op_add_with_carry_acc, srx_op_add_with_carry_mem, srx_op_subtract_acc,
      srx_op_subtract_with_borrow_acc
   } srx_op_t;
   typedef enum logic [1:0] {srx_rep_none, srx_rep_plain, srx_rep_while_equal, srx_rep_while_not_equal} srx_rep_t;
   localparam logic [2:0] INSERT_LEN_REG = 3'h3;
   localparam logic [2:0] INSERT_LEN_IMM = 3'h4;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   localparam int FLAG_AUX = 0;
   localparam int FLAG_CARRY = 1;
   localparam int FLAG_OVER = 2;
   localparam int FLAG_PARITY = 3;
   localparam int FLAG_SIGN = 4;
   localparam int FLAG_ZERO = 5;
   localparam logic [5:0] FLAGS_RESET = 6'h00;
   localparam logic [15:0] REG_RESET = 16'h0000;
endpackage
`default_nettype wire

// >>> core/srx_exec.sv
// Executor for repeat prefixes, string primitives, bit-field insert and add/subtract with carry
`default_nettype none
module srx_exec (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Instruction issue
   input wire logic start,
   input wire srx_pkg::srx_op_t op,
   input wire srx_pkg::srx_rep_t rep,
   input wire logic width_word,
   input wire logic direction,
   input wire logic insert_len_imm,
   input wire logic [15:0] immediate,
   input wire logic [15:0] reg_operand,
   // Architectural state loaded at issue
   input wire logic [15:0] count_init,
   input wire logic [15:0] source_index_init,
   input wire logic [15:0] destination_index_init,
   input wire logic [15:0] accumulator_init,
   input wire logic carry_init,
   // Interrupt handshake
   input wire logic irq_pending,
   input wire logic irq_done,
   // Memory port, single cycle read data
   input wire logic [15:0] mem_rdata,
   // Status
   output logic busy,
   output logic done,
   output logic irq_ack,
   output logic [2:0] insert_length,
   // Memory requests
   output logic mem_rd,
   output logic mem_wr,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   output logic mem_word,
   // Architectural results
   output logic [15:0] count_register,
   output logic [15:0] source_index,
   output logic [15:0] destination_index,
   output logic [15:0] accumulator_word,
   output logic [5:0] flags
);
   typedef enum logic [2:0] {srx_idle, srx_rd_a, srx_rd_b, srx_wr, srx_next, srx_irq} srx_state_t;

   // Release is retimed so every register leaves reset on the same edge
   logic rst_meta_reg;
   logic rst_sync_reg;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // Add or subtract, byte or word, yielding result and the six flags
   function automatic logic [21:0] alu(input logic [15:0] a,
                                       input logic [15:0] b,
                                       input logic cin,
                                       input logic sub,
                                       input logic word);
      logic [16:0] sum;
      logic [15:0] bb;
      logic [15:0] r;
      logic [5:0] f;
      bb = sub ? ~b : b;
      sum = {1'b0, a} + {1'b0, bb} + {16'h0000, sub ^ cin};
      r = word ? sum[15:0] : {8'h00, sum[7:0]};
      f = 6'h00;
      f[srx_pkg::FLAG_AUX] = a[4] ^ b[4] ^ sum[4];
      if (word) begin
         f[srx_pkg::FLAG_CARRY] = sum[16] ^ sub;
         f[srx_pkg::FLAG_OVER] = (a[15] == bb[15]) && (sum[15] != a[15]);
         f[srx_pkg::FLAG_SIGN] = sum[15];
         f[srx_pkg::FLAG_ZERO] = (sum[15:0] == 16'h0000);
      end else begin
         f[srx_pkg::FLAG_CARRY] = (a[8] ^ bb[8] ^ sum[8]) ^ sub;
         f[srx_pkg::FLAG_OVER] = (a[7] == bb[7]) && (sum[7] != a[7]);
         f[srx_pkg::FLAG_SIGN] = sum[7];
         f[srx_pkg::FLAG_ZERO] = (sum[7:0] == 8'h00);
      end
      f[srx_pkg::FLAG_PARITY] = ~^sum[7:0];
      return {f, r};
   endfunction

   srx_state_t state_reg;
   srx_pkg::srx_op_t op_reg;
   srx_pkg::srx_rep_t rep_reg;
   logic word_reg;
   logic dir_reg;
   logic carry_reg;
   logic len_imm_reg;
   logic [15:0] imm_reg;
   logic [15:0] regop_reg;
   logic [15:0] tmp_reg;

   // Decode of the latched operation, shared by the sequencer and the selectors
   wire op_move = op_reg == srx_pkg::srx_op_block_move;
   wire op_bcmp = op_reg == srx_pkg::srx_op_block_compare;
   wire op_acmp = op_reg == srx_pkg::srx_op_compare_with_accumulator;
   wire op_load = op_reg == srx_pkg::srx_op_load_string;
   wire op_store = op_reg == srx_pkg::srx_op_store_string;
   wire op_insert = op_reg == srx_pkg::srx_op_bit_field_insert;
   wire op_adc_acc = op_reg == srx_pkg::srx_op_add_with_carry_acc;
   wire op_adc_mem = op_reg == srx_pkg::srx_op_add_with_carry_mem;
   wire op_sub_acc = op_reg == srx_pkg::srx_op_subtract_acc;
   wire rep_on = rep_reg != srx_pkg::srx_rep_none;
   wire rep_eq = rep_reg == srx_pkg::srx_rep_while_equal;
   wire rep_ne = rep_reg == srx_pkg::srx_rep_while_not_equal;
   wire is_string = op_move || op_bcmp || op_acmp || op_load || op_store;
   wire is_cmp = op_bcmp || op_acmp;
   wire uses_src = op_move || op_bcmp || op_load;
   wire uses_dst = !op_load;
   wire [15:0] step = word_reg ? srx_pkg::STEP_WORD : srx_pkg::STEP_BYTE;
   wire [15:0] src_next = dir_reg ? source_index - step : source_index + step;
   wire [15:0] dst_next = dir_reg ? destination_index - step : destination_index + step;
   wire [15:0] acc_sel = word_reg ? accumulator_word : {8'h00, accumulator_word[7:0]};
   wire [15:0] rd_sel = word_reg ? mem_rdata : {8'h00, mem_rdata[7:0]};
   wire [15:0] imm_sel = word_reg ? imm_reg : {8'h00, imm_reg[7:0]};
   wire [15:0] reg_sel = word_reg ? regop_reg : {8'h00, regop_reg[7:0]};
   // Every arithmetic path yields all six flags, so each form updates them alike
   wire [21:0] cmp_blk = alu(tmp_reg, rd_sel, 1'b0, 1'b1, word_reg);
   wire [21:0] cmp_acc = alu(acc_sel, rd_sel, 1'b0, 1'b1, word_reg);
   wire [21:0] adc_acc = alu(acc_sel, imm_sel, carry_reg, 1'b0, word_reg);
   wire [21:0] adc_mem = alu(rd_sel, reg_sel, carry_reg, 1'b0, word_reg);
   wire [21:0] sub_acc = alu(acc_sel, imm_sel, 1'b0, 1'b1, word_reg);
   wire [21:0] sbb_acc = alu(acc_sel, imm_sel, carry_reg, 1'b1, word_reg);
   wire [15:0] acc_merge_imm = op_adc_acc ? adc_acc[15:0] :
                               op_sub_acc ? sub_acc[15:0] :
                               sbb_acc[15:0];
   wire [5:0] flags_imm = op_adc_acc ? adc_acc[21:16] :
                          op_sub_acc ? sub_acc[21:16] :
                          sbb_acc[21:16];
   wire [15:0] acc_written = word_reg ? acc_merge_imm : {accumulator_word[15:8], acc_merge_imm[7:0]};
   wire [15:0] acc_loaded = word_reg ? mem_rdata : {accumulator_word[15:8], mem_rdata[7:0]};
   wire [15:0] cnt_dec = count_register - 16'h0001;
   wire zero_now = flags[srx_pkg::FLAG_ZERO];
   wire cmp_exit = is_cmp && ((rep_eq && !zero_now) ||
                              (rep_ne && zero_now));
   wire count_zero = (count_register == 16'h0000);
   // Loop ends on a zero count, a failed compare, or a plain instruction
   wire loop_end = !rep_on || count_zero || cmp_exit;
   wire skip_all = is_string && rep_on && count_zero;
   wire first_rd_src = uses_src;
   wire need_read = !op_store && !op_insert;
   wire start_read = need_read && (is_string || op_adc_mem);

   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         state_reg <= srx_idle;
         op_reg <= srx_pkg::srx_op_none;
         rep_reg <= srx_pkg::srx_rep_none;
         word_reg <= 1'b0;
         dir_reg <= 1'b0;
         carry_reg <= 1'b0;
         len_imm_reg <= 1'b0;
         imm_reg <= srx_pkg::REG_RESET;
         regop_reg <= srx_pkg::REG_RESET;
         tmp_reg <= srx_pkg::REG_RESET;
         busy <= 1'b0;
         done <= 1'b0;
         irq_ack <= 1'b0;
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_word <= 1'b0;
         insert_length <= 3'h0;
         mem_addr <= srx_pkg::REG_RESET;
         mem_wdata <= srx_pkg::REG_RESET;
         count_register <= srx_pkg::REG_RESET;
         source_index <= srx_pkg::REG_RESET;
         destination_index <= srx_pkg::REG_RESET;
         accumulator_word <= srx_pkg::REG_RESET;
         flags <= srx_pkg::FLAGS_RESET;
      end else begin
         done <= 1'b0;
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         unique case (state_reg)
            // Operands are latched so the issuer may change them at once
            srx_idle: if (start) begin
               op_reg <= op;
               rep_reg <= rep;
               word_reg <= width_word;
               dir_reg <= direction;
               len_imm_reg <= insert_len_imm;
               carry_reg <= carry_init;
               imm_reg <= immediate;
               regop_reg <= reg_operand;
               count_register <= count_init;
               source_index <= source_index_init;
               destination_index <= destination_index_init;
               accumulator_word <= accumulator_init;
               flags[srx_pkg::FLAG_CARRY] <= carry_init;
               flags[srx_pkg::FLAG_ZERO] <= 1'b0;
               mem_word <= width_word;
               busy <= 1'b1;
               state_reg <= srx_next;
            end
            srx_next: begin
               // Test the loop before each element so a zero count runs nothing
               if (skip_all) begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  state_reg <= srx_idle;
               end else if (op_insert) begin
                  insert_length <= len_imm_reg ? srx_pkg::INSERT_LEN_IMM : srx_pkg::INSERT_LEN_REG;
                  mem_addr <= destination_index;
                  mem_wdata <= accumulator_word;
                  mem_word <= 1'b1;
                  mem_wr <= 1'b1;
                  state_reg <= srx_wr;
               end else if (op_store) begin
                  mem_addr <= destination_index;
                  mem_wdata <= acc_sel;
                  mem_wr <= 1'b1;
                  state_reg <= srx_wr;
               end else if (start_read) begin
                  mem_addr <= first_rd_src ? source_index : destination_index;
                  mem_rd <= 1'b1;
                  state_reg <= srx_rd_a;
               end else begin
                  accumulator_word <= acc_written;
                  flags <= flags_imm;
                  state_reg <= srx_wr;
               end
            end
            // Read data stands in the same cycle as mem_rd, which is high in this state
            srx_rd_a: begin
               tmp_reg <= rd_sel;
               unique case (op_reg)
                  srx_pkg::srx_op_block_move: begin
                     mem_addr <= destination_index;
                     mem_wdata <= rd_sel;
                     mem_wr <= 1'b1;
                     state_reg <= srx_wr;
                  end
                  srx_pkg::srx_op_block_compare: begin
                     mem_addr <= destination_index;
                     mem_rd <= 1'b1;
                     state_reg <= srx_rd_b;
                  end
                  srx_pkg::srx_op_compare_with_accumulator: begin
                     flags <= cmp_acc[21:16];
                     state_reg <= srx_wr;
                  end
                  srx_pkg::srx_op_load_string: begin
                     accumulator_word <= acc_loaded;
                     state_reg <= srx_wr;
                  end
                  srx_pkg::srx_op_add_with_carry_mem: begin
                     mem_wdata <= adc_mem[15:0];
                     flags <= adc_mem[21:16];
                     mem_wr <= 1'b1;
                     state_reg <= srx_wr;
                  end
                  // Unreachable codes still lead the sequencer back to idle
                  default: state_reg <= srx_wr;
               endcase
            end
            srx_rd_b: begin
               flags <= cmp_blk[21:16];
               state_reg <= srx_wr;
            end
            srx_wr: begin
               // Indexes step after every element, repeated or not
               if (is_string && uses_src) begin
                  source_index <= src_next;
               end
               if (is_string && uses_dst) begin
                  destination_index <= dst_next;
               end
               if (is_string && rep_on) begin
                  count_register <= cnt_dec;
                  state_reg <= srx_irq;
               end else begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  state_reg <= srx_idle;
               end
            end
            srx_irq: begin
               // Loop test sees the decremented count and fresh flags
               if (loop_end) begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  state_reg <= srx_idle;
               end else if (irq_pending && !irq_ack) begin
                  irq_ack <= 1'b1;
               end else if (irq_ack) begin
                  // No element runs until the service hands back
                  if (irq_done) begin
                     irq_ack <= 1'b0;
                     state_reg <= srx_next;
                  end
               end else begin
                  state_reg <= srx_next;
               end
            end
            default: state_reg <= srx_idle;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> test/srx_exec_asserts.sv
// Concurrent checks for the string, repeat and add/subtract executor
`default_nettype none
module srx_exec_asserts (
   // Clock, reset and issue
   input wire logic clock,
   input wire logic reset_n,
   input wire logic start,
   input wire srx_pkg::srx_op_t op,
   input wire srx_pkg::srx_rep_t rep,
   input wire logic width_word,
   input wire logic direction,
   input wire logic [15:0] source_index_init,
   input wire logic [15:0] destination_index_init,
   // Outputs
   input wire logic busy,
   input wire logic done,
   input wire logic irq_ack,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [15:0] count_register,
   input wire logic [15:0] source_index,
   input wire logic [15:0] destination_index,
   input wire logic [5:0] flags
);
   srx_pkg::srx_op_t op_reg;
   srx_pkg::srx_rep_t rep_reg;
   logic word_reg, dir_reg;
   logic [15:0] src_reg, dst_reg;
   wire take = start && !busy;
   wire is_acc = op == srx_pkg::srx_op_add_with_carry_acc || op == srx_pkg::srx_op_subtract_acc
      || op == srx_pkg::srx_op_subtract_with_borrow_acc;
   wire is_cmp = op_reg == srx_pkg::srx_op_block_compare || op_reg == srx_pkg::srx_op_compare_with_accumulator;
   wire [15:0] step = word_reg ? srx_pkg::STEP_WORD : srx_pkg::STEP_BYTE;
   wire [15:0] src_next = dir_reg ? src_reg - step : src_reg + step;
   wire [15:0] dst_next = dir_reg ? dst_reg - step : dst_reg + step;
   // Issue fields leave the inputs long before done, so keep a copy
   always_ff @(posedge clock) begin
      if (take) begin
         op_reg <= op;
         rep_reg <= rep;
         word_reg <= width_word;
         dir_reg <= direction;
         src_reg <= source_index_init;
         dst_reg <= destination_index_init;
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   AST_DONE_ONE_CYCLE: assert property (done |=> !done)
      else $error("done held past one cycle");
   AST_ACC_ANSWER: assert property (take && is_acc |-> ##3 done)
      else $error("accumulator op answer late");
   AST_COUNT_STEP: assert property (busy && $past(busy, 2) && $changed(count_register)
      |-> count_register == $past(count_register) - 16'h0001) else $error("count not stepped by one");
   AST_IRQ_QUIET: assert property (irq_ack |-> !mem_rd && !mem_wr)
      else $error("memory access during interrupt service");
   AST_EQ_EXIT: assert property (done && is_cmp && rep_reg == srx_pkg::srx_rep_while_equal
      && count_register != 16'h0000 |-> !flags[srx_pkg::FLAG_ZERO]) else $error("early exit with zero set");
   AST_NE_EXIT: assert property (done && is_cmp && rep_reg == srx_pkg::srx_rep_while_not_equal
      && count_register != 16'h0000 |-> flags[srx_pkg::FLAG_ZERO]) else $error("early exit with zero clear");
   AST_LOAD_STEP: assert property (done && op_reg == srx_pkg::srx_op_load_string
      && rep_reg == srx_pkg::srx_rep_none |-> source_index == src_next && destination_index == dst_reg)
      else $error("load index step wrong");
   AST_STORE_STEP: assert property (done && op_reg == srx_pkg::srx_op_store_string
      && rep_reg == srx_pkg::srx_rep_none |-> destination_index == dst_next && source_index == src_reg)
      else $error("store index step wrong");
   AST_CMP_NO_WRITE: assert property (busy && is_cmp |-> !mem_wr)
      else $error("compare wrote memory");
endmodule
bind srx_exec srx_exec_asserts u_srx_asserts (.clock(clock), .reset_n(reset_n), .start(start), .op(op), .rep(rep),
   .width_word(width_word), .direction(direction), .source_index_init(source_index_init),
   .destination_index_init(destination_index_init), .busy(busy), .done(done), .irq_ack(irq_ack), .mem_rd(mem_rd),
   .mem_wr(mem_wr), .count_register(count_register), .source_index(source_index),
   .destination_index(destination_index), .flags(flags));
`default_nettype wire

// >>> test/srx_exec_tb.sv
// Self-checking bench for the string, repeat and add/subtract executor
`default_nettype none
module srx_exec_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [72:0] REGS = {3'h0, {4{16'hFFFF}}, 6'h00};
   localparam logic [72:0] COMPARE_WITH_ACCUMULATOR = {3'h0, {4{16'hFFFF}}, 6'h20};
   localparam logic [72:0] ACCF = {3'h7, 48'h0, 16'hFFFF, 6'h3F};
   logic clock, reset_n, start, width_word, direction, insert_len_imm, carry_init, irq_pending, irq_done;
   srx_pkg::srx_op_t op;
   srx_pkg::srx_rep_t rep;
   logic [15:0] immediate, reg_operand, count_init, source_index_init, destination_index_init, accumulator_init;
   logic [15:0] mem_rdata, mem_addr, mem_wdata, count_register, source_index, destination_index, accumulator_word;
   logic busy, done, irq_ack, mem_rd, mem_wr, mem_word;
   logic [2:0] insert_length;
   logic [5:0] flags;
   logic [7:0] mem [0:255];
   logic [15:0] rd_noise;
   assign mem_rdata = (mem_rd === 1'b1) ? {mem[mem_addr[7:0] + 8'h01], mem[mem_addr[7:0]]} : rd_noise;
   logic [72:0] exp_q [$], mask_q [$], m;
   int err_total, num_checks, seed, acks, irq_wait;
   srx_exec dut (.clock(clock), .reset_n(reset_n), .start(start), .op(op), .rep(rep), .width_word(width_word),
      .direction(direction), .insert_len_imm(insert_len_imm), .immediate(immediate), .reg_operand(reg_operand),
      .count_init(count_init), .source_index_init(source_index_init), .destination_index_init(destination_index_init),
      .accumulator_init(accumulator_init), .carry_init(carry_init), .irq_pending(irq_pending), .irq_done(irq_done),
      .mem_rdata(mem_rdata), .busy(busy), .done(done), .irq_ack(irq_ack), .insert_length(insert_length),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_word(mem_word),
      .count_register(count_register), .source_index(source_index), .destination_index(destination_index),
      .accumulator_word(accumulator_word), .flags(flags));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   function automatic logic [72:0] mk(input logic [2:0] l, input logic [15:0] n, s, d, a, input logic [5:0] f);
      return {l, n, s, d, a, f};
   endfunction
   // Reference {result, flags}; a byte op keeps the high accumulator byte
   function automatic logic [21:0] alu(input logic [15:0] a, b, input logic c, sub, w);
      logic [15:0] x, y, t;
      logic [16:0] r;
      int h;
      h = w ? 15 : 7;
      x = w ? a : {8'h00, a[7:0]};
      y = w ? b : {8'h00, b[7:0]};
      r = sub ? {1'b0, x} - {1'b0, y} - 17'(c) : {1'b0, x} + {1'b0, y} + 17'(c);
      t = x ^ y ^ r[15:0];
      return {w ? r[15:0] : {a[15:8], r[7:0]}, (w ? r[15:0] : {8'h00, r[7:0]}) == 16'h0000, r[h], ~^r[7:0],
         (x[h] ^ y[h] ^ sub) == 1'b0 && r[h] != x[h], w ? r[16] : r[8], t[4]};
   endfunction
   task automatic check(input logic [72:0] g, e);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic issue(input srx_pkg::srx_op_t o, input srx_pkg::srx_rep_t r, input logic [15:0] n, s, d, a, i,
         input logic [72:0] e, mk_mask);
      int k;
      exp_q.push_back(e);
      mask_q.push_back(mk_mask);
      op <= o;
      rep <= r;
      count_init <= n;
      source_index_init <= s;
      destination_index_init <= d;
      accumulator_init <= a;
      immediate <= i;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 300) begin
         @(posedge clock);
         k++;
      end
      if (k == 300) begin
         check(73'h1, 73'h0);
         tally_and_finish();
      end
      @(posedge clock);
   endtask
   // Memory answers while the read request stands; between reads its data wanders
   always @(posedge clock) begin
      rd_noise <= ~rd_noise;
      if (mem_wr === 1'b1) begin
         mem[mem_addr[7:0]] <= mem_wdata[7:0];
         if (mem_word) mem[mem_addr[7:0] + 8'h01] <= mem_wdata[15:8];
      end
      irq_done <= irq_ack === 1'b1 && irq_wait == 2;
      irq_wait <= (irq_ack === 1'b1 && irq_wait < 2) ? irq_wait + 1 : 0;
      if (irq_ack === 1'b1 && irq_wait == 2) begin
         irq_pending <= 1'b0;
         acks <= acks + 1;
      end
      if (done === 1'b1 && exp_q.size() == 0) check(73'h1, 73'h0);
      else if (done === 1'b1) begin
         m = mask_q.pop_front();
         check(mk(insert_length, count_register, source_index, destination_index, accumulator_word, flags) & m,
            exp_q.pop_front() & m);
      end
   end
   initial begin
      #100000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      logic [15:0] a, b, s, d, st;
      logic [21:0] r;
      logic c, w;
      int lo;
      srx_pkg::srx_op_t o;
      seed = 75;
      {reset_n, start, width_word, direction, insert_len_imm, carry_init, irq_pending, irq_done} = '0;
      {immediate, reg_operand, count_init, source_index_init, destination_index_init, accumulator_init} = '0;
      op = srx_pkg::srx_op_none;
      rep = srx_pkg::srx_rep_none;
      rd_noise = 16'hA5C3;
      s = 16'h0040;
      d = 16'h0080;
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      for (int i = 0; i < 12; i++) begin
         o = i % 3 == 0 ? srx_pkg::srx_op_add_with_carry_acc : i % 3 == 1 ? srx_pkg::srx_op_subtract_acc
            : srx_pkg::srx_op_subtract_with_borrow_acc;
         a = 16'($random(seed));
         b = i == 1 ? a : 16'($random(seed));
         {c, w} = 2'($random(seed));
         width_word <= w;
         carry_init <= c;
         r = alu(a, b, c && o != srx_pkg::srx_op_subtract_acc, o != srx_pkg::srx_op_add_with_carry_acc, w);
         issue(o, srx_pkg::srx_rep_none, 0, 0, 0, a, b, mk(0, 0, 0, 0, r[21:6], r[5:0]), ACCF);
      end
      for (int i = 0; i < 4; i++) begin
         w = i[0];
         c = i[1];
         width_word <= w;
         direction <= c;
         st = w ? 16'h0002 : 16'h0001;
         for (int k = 0; k < 256; k++) mem[k] = 8'($random(seed));
         a = 16'($random(seed));
         issue(srx_pkg::srx_op_block_move, srx_pkg::srx_rep_plain, 3, s, d, a, 0,
            mk(0, 0, c ? s - 3 * st : s + 3 * st, c ? d - 3 * st : d + 3 * st, a, 0), REGS);
         lo = c ? -2 * int'(st) : 0;
         for (int k = lo; k < lo + 3 * int'(st); k++) check(73'(mem[8'(128 + k)]), 73'(mem[8'(64 + k)]));
         issue(srx_pkg::srx_op_load_string, srx_pkg::srx_rep_none, 7, s, d, a, 0, mk(0, 7, c ? s - st : s + st, d,
            w ? {mem[8'h41], mem[8'h40]} : {a[15:8], mem[8'h40]}, 0), REGS);
         b = {mem[8'h81], a[7:0]};
         issue(srx_pkg::srx_op_store_string, srx_pkg::srx_rep_none, 7, s, d, a, 0,
            mk(0, 7, s, c ? d - st : d + st, a, 0), REGS);
         check(73'({mem[8'h81], mem[8'h80]}), 73'(w ? a : b));
      end
      width_word <= 1'b0;
      direction <= 1'b0;
      {mem[8'h40], mem[8'h41], mem[8'h42], mem[8'h80], mem[8'h81], mem[8'h82]} = 48'h010203_010209;
      issue(srx_pkg::srx_op_block_compare, srx_pkg::srx_rep_while_equal, 5, s, d, 0, 0,
         mk(0, 2, 16'h0043, 16'h0083, 0, 0), COMPARE_WITH_ACCUMULATOR);
      {mem[8'h80], mem[8'h81], mem[8'h82]} = 24'h112255;
      irq_pending <= 1'b1;
      issue(srx_pkg::srx_op_compare_with_accumulator, srx_pkg::srx_rep_while_not_equal, 5, s, d, 16'h0055, 0,
         mk(0, 2, s, 16'h0083, 16'h0055, 6'h20), COMPARE_WITH_ACCUMULATOR);
      check(73'(acks != 0), 73'h1);
      issue(srx_pkg::srx_op_block_move, srx_pkg::srx_rep_plain, 0, s, d, a, 0, mk(0, 0, s, d, a, 0), REGS);
      check(73'(mem[8'h80]), 73'h11);
      width_word <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         insert_len_imm <= i[0];
         a = 16'($random(seed));
         issue(srx_pkg::srx_op_bit_field_insert, srx_pkg::srx_rep_none, 0, s, d, a, 0,
            mk(i ? 3'h4 : 3'h3, 0, 0, 0, 0, 0), {3'h7, 70'h0});
         check(73'({mem[8'h81], mem[8'h80]}), 73'(a));
      end
      {c, b} = 17'($random(seed));
      a = 16'($random(seed));
      {mem[8'h81], mem[8'h80]} = a;
      carry_init <= c;
      reg_operand <= b;
      r = alu(a, b, c, 1'b0, 1'b1);
      issue(srx_pkg::srx_op_add_with_carry_mem, srx_pkg::srx_rep_none, 0, s, d, 16'h1234, 0,
         mk(srx_pkg::INSERT_LEN_IMM, 0, 0, 0, 16'h1234, r[5:0]), ACCF);
      check(73'({mem[8'h81], mem[8'h80]}), 73'(r[21:6]));
      tally_and_finish();
   end
endmodule
`default_nettype wire
